// >>> design/cst_defines.vh
// register offsets, field positions, reset values of the system register bank
// assumes byte addresses on a 10-bit word-aligned register port
`ifndef CST_DEFINES_VH
`define CST_DEFINES_VH

`define CST_ADDR_W         10
`define CST_OFF_EXCEPTION_VECTOR_BASE       10'h004
`define CST_OFF_CPU_CONTROL_REG      10'h00C
`define CST_OFF_ECR        10'h010
`define CST_OFF_DEBUG_RETURN_STATUS    10'h018
`define CST_OFF_DEBUG_RETURN_ADDRESS    10'h034
`define CST_OFF_CORE_DESCRIPTION_WORD_0    10'h100
`define CST_OFF_CORE_DESCRIPTION_WORD_1    10'h104
`define CST_OFF_COUNT      10'h108
`define CST_OFF_COMPARE    10'h10C
`define CST_OFF_BUS_ERROR_ADDRESS_REG       10'h13C
`define CST_OFF_SEC_FLASH  10'h1A0
`define CST_OFF_SEC_RAM    10'h1A4
`define CST_OFF_SEC_SP_SYS 10'h1B0
`define CST_OFF_SEC_SP_APP 10'h1B4

`define CST_CPU_CONTROL_REG_HOLD_BIT 17
`define CST_CPU_CONTROL_REG_W        18
`define CST_CPU_CONTROL_REG_RST      18'h0_4211

`define CST_ECR_W          7
`define CST_ECR_RST        7'h00
`define CST_ECR_LSB        2
`define CST_ECR_MSB        8
`define CST_ZERO32         32'h0000_0000
`define CST_ONE32          32'h0000_0001

`define CST_CFG0_PID_MSB   31
`define CST_CFG0_PID_LSB   24
`define CST_CFG0_REV_MSB   19
`define CST_CFG0_REV_LSB   16
`define CST_CFG0_AT_MSB    15
`define CST_CFG0_AT_LSB    13
`define CST_CFG0_AR_MSB    12
`define CST_CFG0_AR_LSB    10
`define CST_CFG0_MUT_MSB   9
`define CST_CFG0_MUT_LSB   7
`define CST_CFG0_FLG_MSB   6

`endif

// >>> design/cst_sysreg.v
// core system registers with side effects and the cycle counter/compare timer
// assumes pipeline event strobes are one-cycle pulses on mclk_in
// What this block does
// - exception loads cause from offset bits 8:2
// - supervisor call, breakpoint, debug stop skip cause
// - interrupt cause comes from controller autovector
// - debug entry saves status; return restores it
// - debug entry saves pc; return restores it
// - bus error latches address; writes ignored
// - secure stack copies read current pointers
// - counter increments every cycle, no disable
// - reset clears counter; match clears unless hold
// - hold bit is control bit 17, reset 0
// - counter keeps counting while request pends
// - match raises request, counter restarts at zero unless hold
// - request goes out to interrupt controller
// - compare write clears pending request, unless a match in the same cycle
// - compare zero disables matching entirely
// - compare resets zero; both read/write
// - timer runs on the cpu-rate clock shared with the registers
// - description word 0 read-only id fields
// - description word 1 memory and cache sizes
`timescale 1ns/1ns
`include "cst_defines.vh"

module cst_sysreg #(
  parameter [7:0]  PROC_ID    = 8'h5A,   // arbitrary value
  parameter [3:0]  PROC_REV   = 4'h1,    // arbitrary value
  parameter [2:0]  ARCH_TYPE  = 3'h0,
  parameter [2:0]  ARCH_REV   = 3'h1,
  parameter [2:0]  MEM_UNIT   = 3'h0,
  parameter [6:0]  CAP_FLAGS  = 7'h00,
  parameter [31:0] CFG1_VALUE = 32'h0000_0000
) (
  input  wire        mclk_in,        // cpu-rate timer/register clock
  input  wire        srst_in,        // synchronous reset, high
  input  wire [9:0]  addr_in,        // register byte address
  input  wire [31:0] wdata_in,       // write data
  input  wire        wr_in,          // write strobe
  input  wire        rd_in,          // read strobe
  output reg  [31:0] rdata_out,      // read data, cycle after rd_in
  input  wire        exc_take_in,    // exception taken pulse
  input  wire        exc_no_cause_in,// scall/breakpoint/debug stop
  input  wire        exc_is_irq_in,  // taken exception is interrupt
  input  wire [31:0] exc_offset_in,  // vector offset of exception
  input  wire [31:0] irq_autovec_in, // autovector offset from controller
  input  wire        dbg_enter_in,   // debug mode entry pulse
  input  wire        dbg_return_in,  // return-from-debug pulse
  input  wire [31:0] status_in,      // current status word
  input  wire [31:0] pc_in,          // current program counter
  output reg         restore_out,    // restore strobe, one cycle
  output reg  [31:0] status_out,     // status word to restore
  output reg  [31:0] pc_out,         // program counter to restore
  input  wire        berr_in,        // data bus error pulse
  input  wire [31:0] berr_addr_in,   // physical address of bus error
  input  wire [31:0] sp_sys_in,      // current system stack pointer
  input  wire [31:0] sp_app_in,      // current application stack pointer
  output reg  [31:0] exception_vector_base_out,       // exception vector base
  output reg  [17:0] cpu_ctrl_out,   // cpu control fields
  output reg  [31:0] sec_flash_out,  // secure flash partition
  output reg  [31:0] sec_ram_out,    // secure ram partition
  output reg         cmp_irq_out     // compare interrupt request
);

  reg  [6:0]  cause_r;
  reg  [6:0]  cause_nxt;
  reg  [31:0] dbg_status_r;
  reg  [31:0] dbg_status_nxt;
  reg  [31:0] dbg_addr_r;
  reg  [31:0] dbg_addr_nxt;
  reg  [31:0] berr_addr_r;
  reg  [31:0] berr_addr_nxt;
  reg  [31:0] exception_vector_base_nxt;
  reg  [17:0] cpu_ctrl_nxt;
  reg  [31:0] sec_flash_nxt;
  reg  [31:0] sec_ram_nxt;
  reg  [31:0] count_r;
  reg  [31:0] count_nxt;
  reg  [31:0] compare_r;
  reg  [31:0] compare_nxt;
  reg         irq_nxt;
  reg  [31:0] rdata_nxt;
  wire [31:0] cfg0;
  wire [31:0] cause_src;
  wire        cause_load;
  wire        match;
  wire        match_clear;
  wire        we_exception_vector_base;
  wire        we_cpu_control_reg;
  wire        we_rsr;
  wire        we_rar;
  wire        we_count;
  wire        we_compare;
  wire        we_sflash;
  wire        we_sram;

  // one address compare, shared by write enables and read mux
  function hit;
    input [9:0] a;
    input [9:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // write enables, one per writable register
  assign we_exception_vector_base    = wr_in & hit(addr_in, `CST_OFF_EXCEPTION_VECTOR_BASE);
  assign we_cpu_control_reg   = wr_in & hit(addr_in, `CST_OFF_CPU_CONTROL_REG);
  assign we_rsr     = wr_in & hit(addr_in, `CST_OFF_DEBUG_RETURN_STATUS);
  assign we_rar     = wr_in & hit(addr_in, `CST_OFF_DEBUG_RETURN_ADDRESS);
  assign we_count   = wr_in & hit(addr_in, `CST_OFF_COUNT);
  assign we_compare = wr_in & hit(addr_in, `CST_OFF_COMPARE);
  assign we_sflash  = wr_in & hit(addr_in, `CST_OFF_SEC_FLASH);
  assign we_sram    = wr_in & hit(addr_in, `CST_OFF_SEC_RAM);

  // read-only identification word
  assign cfg0 = {PROC_ID, 4'h0, PROC_REV, ARCH_TYPE, ARCH_REV, MEM_UNIT, CAP_FLAGS};

  // cause source and load condition
  assign cause_src  = exc_is_irq_in ? irq_autovec_in : exc_offset_in;
  assign cause_load = exc_take_in & ~exc_no_cause_in;

  // compare zero turns matching off
  assign match       = (compare_r != `CST_ZERO32) && (count_r == compare_r);
  assign match_clear = match & ~cpu_ctrl_out[`CST_CPU_CONTROL_REG_HOLD_BIT];

  // exception cause next value
  always @* begin
    cause_nxt = cause_r;
    if (cause_load) begin
      cause_nxt = cause_src[`CST_ECR_MSB:`CST_ECR_LSB];
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      cause_r <= `CST_ECR_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // debug entry capture wins over a software write
  always @* begin
    dbg_status_nxt = dbg_status_r;
    if (dbg_enter_in) begin
      dbg_status_nxt = status_in;
    end else if (we_rsr) begin
      dbg_status_nxt = wdata_in;
    end
  end

  always @* begin
    dbg_addr_nxt = dbg_addr_r;
    if (dbg_enter_in) begin
      dbg_addr_nxt = pc_in;
    end else if (we_rar) begin
      dbg_addr_nxt = wdata_in;
    end
  end

  // saved status, live until the next entry or write
  always @(posedge mclk_in) begin
    if (srst_in) begin
      dbg_status_r <= `CST_ZERO32;
    end else begin
      dbg_status_r <= dbg_status_nxt;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      dbg_addr_r <= `CST_ZERO32;
    end else begin
      dbg_addr_r <= dbg_addr_nxt;
    end
  end

  // return from debug hands the saved words back
  always @(posedge mclk_in) begin
    if (srst_in) begin
      restore_out <= 1'b0;
      status_out  <= `CST_ZERO32;
      pc_out      <= `CST_ZERO32;
    end else begin
      restore_out <= dbg_return_in;
      if (dbg_return_in) begin
        status_out <= dbg_status_r;
        pc_out     <= dbg_addr_r;
      end
    end
  end

  // bus error address, software writes have no effect
  always @* begin
    berr_addr_nxt = berr_addr_r;
    if (berr_in) begin
      berr_addr_nxt = berr_addr_in;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      berr_addr_r <= `CST_ZERO32;
    end else begin
      berr_addr_r <= berr_addr_nxt;
    end
  end

  // plain control registers, next values
  always @* begin
    exception_vector_base_nxt = exception_vector_base_out;
    if (we_exception_vector_base) begin
      exception_vector_base_nxt = wdata_in;
    end
  end

  always @* begin
    cpu_ctrl_nxt = cpu_ctrl_out;
    if (we_cpu_control_reg) begin
      cpu_ctrl_nxt = wdata_in[`CST_CPU_CONTROL_REG_W-1:0];
    end
  end

  always @* begin
    sec_flash_nxt = sec_flash_out;
    if (we_sflash) begin
      sec_flash_nxt = wdata_in;
    end
  end

  always @* begin
    sec_ram_nxt = sec_ram_out;
    if (we_sram) begin
      sec_ram_nxt = wdata_in;
    end
  end

  // control registers, straight from flip-flops
  always @(posedge mclk_in) begin
    if (srst_in) begin
      exception_vector_base_out <= `CST_ZERO32;
    end else begin
      exception_vector_base_out <= exception_vector_base_nxt;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      cpu_ctrl_out <= `CST_CPU_CONTROL_REG_RST;
    end else begin
      cpu_ctrl_out <= cpu_ctrl_nxt;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      sec_flash_out <= `CST_ZERO32;
    end else begin
      sec_flash_out <= sec_flash_nxt;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      sec_ram_out <= `CST_ZERO32;
    end else begin
      sec_ram_out <= sec_ram_nxt;
    end
  end

  // counter next value: write, then match clear, then free increment
  always @* begin
    count_nxt = count_r + `CST_ONE32;
    if (we_count) begin
      count_nxt = wdata_in;
    end else if (match_clear) begin
      count_nxt = `CST_ZERO32;
    end
  end

  always @* begin
    compare_nxt = compare_r;
    if (we_compare) begin
      compare_nxt = wdata_in;
    end
  end

  // a match in the write cycle keeps the request set
  always @* begin
    irq_nxt = cmp_irq_out;
    if (match) begin
      irq_nxt = 1'b1;
    end else if (we_compare) begin
      irq_nxt = 1'b0;
    end
  end

  // timer on the cpu-rate clock shared with the registers
  always @(posedge mclk_in) begin
    if (srst_in) begin
      count_r <= `CST_ZERO32;
    end else begin
      count_r <= count_nxt;
    end
  end

  // match value
  always @(posedge mclk_in) begin
    if (srst_in) begin
      compare_r <= `CST_ZERO32;
    end else begin
      compare_r <= compare_nxt;
    end
  end

  // request pending level toward the interrupt controller
  always @(posedge mclk_in) begin
    if (srst_in) begin
      cmp_irq_out <= 1'b0;
    end else begin
      cmp_irq_out <= irq_nxt;
    end
  end

  // read mux
  // unmapped addresses read as zero
  always @* begin
    rdata_nxt = `CST_ZERO32;
    if (hit(addr_in, `CST_OFF_EXCEPTION_VECTOR_BASE)) begin
      rdata_nxt = exception_vector_base_out;
    end else if (hit(addr_in, `CST_OFF_CPU_CONTROL_REG)) begin
      rdata_nxt = {14'h0000, cpu_ctrl_out};
    end else if (hit(addr_in, `CST_OFF_ECR)) begin
      rdata_nxt = {25'h000_0000, cause_r};
    end else if (hit(addr_in, `CST_OFF_DEBUG_RETURN_STATUS)) begin
      rdata_nxt = dbg_status_r;
    end else if (hit(addr_in, `CST_OFF_DEBUG_RETURN_ADDRESS)) begin
      rdata_nxt = dbg_addr_r;
    end else if (hit(addr_in, `CST_OFF_CORE_DESCRIPTION_WORD_0)) begin
      rdata_nxt = cfg0;
    end else if (hit(addr_in, `CST_OFF_CORE_DESCRIPTION_WORD_1)) begin
      rdata_nxt = CFG1_VALUE;
    end else if (hit(addr_in, `CST_OFF_COUNT)) begin
      rdata_nxt = count_r;
    end else if (hit(addr_in, `CST_OFF_COMPARE)) begin
      rdata_nxt = compare_r;
    end else if (hit(addr_in, `CST_OFF_BUS_ERROR_ADDRESS_REG)) begin
      rdata_nxt = berr_addr_r;
    end else if (hit(addr_in, `CST_OFF_SEC_FLASH)) begin
      rdata_nxt = sec_flash_out;
    end else if (hit(addr_in, `CST_OFF_SEC_RAM)) begin
      rdata_nxt = sec_ram_out;
    end else if (hit(addr_in, `CST_OFF_SEC_SP_SYS)) begin
      rdata_nxt = sp_sys_in;
    end else if (hit(addr_in, `CST_OFF_SEC_SP_APP)) begin
      rdata_nxt = sp_app_in;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge mclk_in) begin
    if (srst_in) begin
      rdata_out <= `CST_ZERO32;
    end else if (rd_in) begin
      rdata_out <= rdata_nxt;
    end else begin
      rdata_out <= `CST_ZERO32;
    end
  end

endmodule // cst_sysreg

// >>> verification/cst_sysreg_checker.sv
// checker: bus, timer and event relations at the register bank ports
// assumes binding onto cst_sysreg, one clock, reset high
`timescale 1ns/1ns
`include "cst_defines.vh"
module cst_sysreg_checker (
  input wire        mclk_in, srst_in, wr_in, rd_in, exc_take_in, exc_no_cause_in,
  input wire        exc_is_irq_in, dbg_enter_in, dbg_return_in, berr_in, restore_out,
  input wire        cmp_irq_out,
  input wire [9:0]  addr_in,
  input wire [31:0] wdata_in, rdata_out, exc_offset_in, status_in, pc_in, status_out,
  input wire [31:0] pc_out, berr_addr_in, sp_sys_in
);
  reg [31:0] cmp_r; // compare value as software left it
  always @(posedge mclk_in)
    if (srst_in) cmp_r <= 32'h0000_0000;
    else if (wr_in && addr_in == `CST_OFF_COMPARE) cmp_r <= wdata_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  property p_idle; !$past(rd_in) |-> rdata_out == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  property p_rest; restore_out |-> $past(dbg_return_in); endproperty
  a_rest: assert property (p_rest) else $error("restore without return");
  property p_fall; $fell(cmp_irq_out) |-> $past(wr_in && addr_in == `CST_OFF_COMPARE); endproperty
  a_fall: assert property (p_fall) else $error("request dropped without write");
  property p_rise; $rose(cmp_irq_out) |-> $past(cmp_r) != 32'h0000_0000; endproperty
  a_rise: assert property (p_rise) else $error("request with zero compare");
  property p_ecr; (exc_take_in && !exc_no_cause_in && !exc_is_irq_in) ##1
    (rd_in && addr_in == `CST_OFF_ECR && !exc_take_in)
    |=> rdata_out == (($past(exc_offset_in, 2) >> 2) & 32'h0000_007F); endproperty
  a_ecr: assert property (p_ecr) else $error("cause value wrong");
  property p_bus_error_address_reg; berr_in ##1 (rd_in && addr_in == `CST_OFF_BUS_ERROR_ADDRESS_REG && !berr_in)
    |=> rdata_out == $past(berr_addr_in, 2); endproperty
  a_bus_error_address_reg: assert property (p_bus_error_address_reg) else $error("bus error address wrong");
  property p_sp; rd_in && addr_in == `CST_OFF_SEC_SP_SYS |=> rdata_out == $past(sp_sys_in);
  endproperty
  a_sp: assert property (p_sp) else $error("stack copy wrong");
  property p_dbg; dbg_enter_in ##1 (dbg_return_in && !dbg_enter_in) |=> restore_out
    && status_out == $past(status_in, 2) && pc_out == $past(pc_in, 2); endproperty
  a_dbg: assert property (p_dbg) else $error("debug restore wrong");
endmodule // cst_sysreg_checker
bind cst_sysreg cst_sysreg_checker cst_sysreg_checker_i (.mclk_in(mclk_in), .srst_in(srst_in),
  .wr_in(wr_in), .rd_in(rd_in), .exc_take_in(exc_take_in), .exc_no_cause_in(exc_no_cause_in),
  .exc_is_irq_in(exc_is_irq_in), .dbg_enter_in(dbg_enter_in), .dbg_return_in(dbg_return_in),
  .berr_in(berr_in), .restore_out(restore_out), .cmp_irq_out(cmp_irq_out), .addr_in(addr_in),
  .wdata_in(wdata_in), .rdata_out(rdata_out), .exc_offset_in(exc_offset_in),
  .status_in(status_in), .pc_in(pc_in), .status_out(status_out), .pc_out(pc_out),
  .berr_addr_in(berr_addr_in), .sp_sys_in(sp_sys_in));

// >>> verification/cst_far_model.sv
// far side: interrupt controller taking the compare request
// assumes the register bank clock and reset
`timescale 1ns/1ns
module cst_far_model #(
  parameter [31:0] AUTOVEC = 32'h0000_0148
) (
  input  wire        mclk_in,     // clock
  input  wire        srst_in,     // reset, high
  input  wire        irq_in,      // compare request
  output wire [31:0] autovec_out, // offset handed to the core
  output reg  [7:0]  seen_out     // requests noticed
);
  reg irq_r;
  assign autovec_out = AUTOVEC;
  always @(posedge mclk_in) begin
    irq_r    <= irq_in & !srst_in;
    seen_out <= srst_in ? 8'h00 : seen_out + {7'h00, irq_in & !irq_r};
  end
endmodule // cst_far_model

// >>> verification/cst_sysreg_test.sv
// testbench: register bank reads, timer, exceptions, debug and bus error
// assumes the checker bound in and the far side model beside
`timescale 1ns/1ns
`include "cst_defines.vh"
module cst_sysreg_test;
  reg         mclk_in = 0, srst_in = 1, wr_in = 0, rd_in = 0, exc_take_in = 0, berr_in = 0;
  reg         exc_no_cause_in = 0, exc_is_irq_in = 0, dbg_enter_in = 0, dbg_return_in = 0;
  reg  [9:0]  addr_in = 0;
  reg  [31:0] wdata_in = 0, exc_offset_in = 0, status_in = 0, pc_in = 0, berr_addr_in = 0;
  reg  [31:0] sp_sys_in = 0, sp_app_in = 0, seed = 32'd79897, v, e;
  reg  [31:0] q[$];
  wire [31:0] rdata_out, irq_autovec_in, status_out, pc_out, exception_vector_base_out, sec_flash_out, sec_ram_out;
  wire [17:0] cpu_ctrl_out;
  wire [7:0]  seen;
  wire        restore_out, cmp_irq_out;
  integer     err_total = 0, total_checks = 0, i, p1 = 0;
  cst_sysreg cst_sysreg_i (.mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .exc_take_in(exc_take_in), .exc_no_cause_in(exc_no_cause_in), .exc_is_irq_in(exc_is_irq_in),
    .exc_offset_in(exc_offset_in), .irq_autovec_in(irq_autovec_in), .dbg_enter_in(dbg_enter_in),
    .dbg_return_in(dbg_return_in), .status_in(status_in), .pc_in(pc_in),
    .restore_out(restore_out), .status_out(status_out), .pc_out(pc_out), .berr_in(berr_in),
    .berr_addr_in(berr_addr_in), .sp_sys_in(sp_sys_in), .sp_app_in(sp_app_in),
    .exception_vector_base_out(exception_vector_base_out), .cpu_ctrl_out(cpu_ctrl_out), .sec_flash_out(sec_flash_out),
    .sec_ram_out(sec_ram_out), .cmp_irq_out(cmp_irq_out));
  cst_far_model cst_far_model_i (.mclk_in(mclk_in), .srst_in(srst_in), .irq_in(cmp_irq_out),
    .autovec_out(irq_autovec_in), .seen_out(seen));
  function [31:0] xs(input integer u); begin
    seed = seed ^ (seed << 13); seed = seed ^ (seed >> 17); seed = seed ^ (seed << 5); xs = seed;
  end endfunction
  task chk(input [31:0] s, input [31:0] x); begin
    total_checks = total_checks + 1;
    if (s !== x) begin
      err_total = err_total + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  end endtask
  task w(input [9:0] a, input [31:0] d); begin
    {wr_in, rd_in} <= 2'b10; addr_in <= a; wdata_in <= d; @(posedge mclk_in);
  end endtask
  task r(input [9:0] a, input [31:0] x); begin
    {wr_in, rd_in} <= 2'b01; addr_in <= a; q.push_back(x); @(posedge mclk_in);
  end endtask
  task idle(input integer n); begin
    {wr_in, rd_in} <= 2'b00; repeat (n) @(posedge mclk_in);
  end endtask
  task exc(input nc, input irq, input [31:0] o); begin
    {wr_in, rd_in} <= 2'b00; exc_take_in <= 1'b1; exc_no_cause_in <= nc; exc_is_irq_in <= irq;
    exc_offset_in <= o; @(posedge mclk_in); exc_take_in <= 1'b0;
  end endtask
  task finish_test; begin
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  end endtask
  initial forever #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (p1) chk(rdata_out, q.pop_front());
    p1 = rd_in;
  end
  initial begin
    repeat (2000) @(posedge mclk_in);
    err_total = err_total + 1;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    r(`CST_OFF_CPU_CONTROL_REG, 32'h0000_4211); r(`CST_OFF_COMPARE, 32'h0000_0000);
    w(`CST_OFF_CORE_DESCRIPTION_WORD_0, 32'hFFFF_FFFF); r(`CST_OFF_CORE_DESCRIPTION_WORD_0, 32'h5A01_0400);
    r(`CST_OFF_CORE_DESCRIPTION_WORD_1, 32'h0000_0000); r(10'h3F0, 32'h0000_0000);
    v = xs(0); w(`CST_OFF_EXCEPTION_VECTOR_BASE, v); r(`CST_OFF_EXCEPTION_VECTOR_BASE, v);
    chk(exception_vector_base_out, v);
    v = xs(0) & 32'hFFFF_FC00; w(`CST_OFF_SEC_FLASH, v); r(`CST_OFF_SEC_FLASH, v);
    chk(sec_flash_out, v);
    v = xs(0) & 32'hFFFF_FC00; w(`CST_OFF_SEC_RAM, v); r(`CST_OFF_SEC_RAM, v);
    chk(sec_ram_out, v);
    v = xs(0); w(`CST_OFF_DEBUG_RETURN_STATUS, v); r(`CST_OFF_DEBUG_RETURN_STATUS, v);
    v = xs(0); w(`CST_OFF_DEBUG_RETURN_ADDRESS, v); r(`CST_OFF_DEBUG_RETURN_ADDRESS, v);
    v = xs(0); sp_sys_in <= v; r(`CST_OFF_SEC_SP_SYS, v);
    e = xs(0); sp_app_in <= e; r(`CST_OFF_SEC_SP_APP, e);
    $display("registers done");
    w(`CST_OFF_COUNT, 32'hFFFF_FFFE); idle(2); r(`CST_OFF_COUNT, 32'h0000_0000);
    w(`CST_OFF_COMPARE, 32'h0000_0003); w(`CST_OFF_COUNT, 32'h0000_0000);
    for (i = 0; i < 6; i = i + 1) r(`CST_OFF_COUNT, i % 4);
    chk(cmp_irq_out, 1);
    w(`CST_OFF_CPU_CONTROL_REG, 32'h0002_4211); w(`CST_OFF_COUNT, 32'h0000_0000);
    chk(cpu_ctrl_out, 32'h0002_4211);
    for (i = 0; i < 6; i = i + 1) r(`CST_OFF_COUNT, i);
    w(`CST_OFF_COMPARE, 32'h0000_0000); idle(1); chk(cmp_irq_out, 0);
    w(`CST_OFF_COUNT, 32'h0000_0000); idle(4); chk(cmp_irq_out, 0);
    chk(seen, 1);
    $display("timer done");
    v = xs(0); exc(0, 0, v); r(`CST_OFF_ECR, (v >> 2) & 32'h7F);
    exc(1, 0, ~v); r(`CST_OFF_ECR, (v >> 2) & 32'h7F);
    exc(0, 1, v); r(`CST_OFF_ECR, (irq_autovec_in >> 2) & 32'h7F);
    v = xs(0); idle(0); berr_in <= 1'b1; berr_addr_in <= v; @(posedge mclk_in);
    berr_in <= 1'b0; r(`CST_OFF_BUS_ERROR_ADDRESS_REG, v); w(`CST_OFF_BUS_ERROR_ADDRESS_REG, ~v); r(`CST_OFF_BUS_ERROR_ADDRESS_REG, v);
    v = xs(0); e = xs(0); idle(0); status_in <= v; pc_in <= e; dbg_enter_in <= 1'b1;
    @(posedge mclk_in);
    dbg_enter_in <= 1'b0; dbg_return_in <= 1'b1; status_in <= ~v; pc_in <= ~e;
    @(posedge mclk_in);
    dbg_return_in <= 1'b0;
    @(posedge mclk_in);
    chk(restore_out, 1); chk(status_out, v); chk(pc_out, e);
    $display("events done");
    finish_test;
  end
endmodule // cst_sysreg_test
